// ===== hw/dacmc_pkg.sv
// Constants of the DAC mode control register bank.
// Assumes a 100 MHz ref_clk; control pins are asynchronous to it.
`default_nettype none

package dacmc_pkg;

    // Clock and ramp timing
    localparam int CLK_PERIOD_NS    = 10;
    localparam int RAMP_STEP_NS     = 166667;  // Eight sample periods at 48 kHz
    localparam int RAMP_STEP_CYCLES = RAMP_STEP_NS / CLK_PERIOD_NS;

    // Control word layout
    localparam int WORD_BITS   = 16;
    localparam int RW_BIT      = 15;
    localparam int IDX_MSB     = 14;
    localparam int IDX_LSB     = 8;
    localparam int HEADER_BITS = 8;
    localparam int CHANNELS    = 8;
    localparam int CH_LOW      = 6;

    // Register indices
    localparam logic [6:0] IDX_ATT1     = 7'h01;
    localparam logic [6:0] IDX_ATT2     = 7'h02;
    localparam logic [6:0] IDX_ATT3     = 7'h03;
    localparam logic [6:0] IDX_ATT4     = 7'h04;
    localparam logic [6:0] IDX_ATT5     = 7'h05;
    localparam logic [6:0] IDX_ATT6     = 7'h06;
    localparam logic [6:0] IDX_MUTE_A   = 7'h07;
    localparam logic [6:0] IDX_OFF_A    = 7'h08;
    localparam logic [6:0] IDX_FORMAT   = 7'h09;
    localparam logic [6:0] IDX_DEEMPH   = 7'h0a;
    localparam logic [6:0] IDX_READBACK = 7'h0b;
    localparam logic [6:0] IDX_GP       = 7'h0c;
    localparam logic [6:0] IDX_ATT7     = 7'h10;
    localparam logic [6:0] IDX_ATT8     = 7'h11;
    localparam logic [6:0] IDX_MUTE_B   = 7'h12;
    localparam logic [6:0] IDX_OFF_B    = 7'h13;
    localparam logic [6:0] IDX_STEP     = 7'h01;

    // Reset values
    localparam logic [7:0] ATT_RESET      = 8'hff;
    localparam logic [7:0] MUTE_RESET     = 8'h00;
    localparam logic [7:0] OFF_RESET      = 8'h00;
    localparam logic [7:0] FORMAT_RESET   = 8'h00;
    localparam logic [7:0] DEEMPH_RESET   = 8'h00;
    localparam logic [7:0] READBACK_RESET = 8'h01;
    localparam logic [7:0] GP_RESET       = 8'h00;

    // Writable bits per register; the rest read as zero
    localparam logic [7:0] MASK_CH_A   = 8'h3f;
    localparam logic [7:0] MASK_CH_B   = 8'h03;
    localparam logic [7:0] MASK_FORMAT = 8'h3f;
    localparam logic [7:0] MASK_DEEMPH = 8'h7f;

    // Field positions
    localparam int FMT_LSB  = 0;
    localparam int FMT_MSB  = 2;
    localparam int CLOCK_OUT_DISABLE_BIT = 3;
    localparam int CLOCK_OUT_HALVING_BIT = 4;
    localparam int FLT_BIT  = 5;
    localparam int DMC_LSB  = 0;
    localparam int DMC_MSB  = 2;
    localparam int DMF_LSB  = 3;
    localparam int DMF_MSB  = 4;
    localparam int OUTPUT_PHASE_INVERT_BIT = 5;
    localparam int ZERO_FLAG_POLARITY_BIT = 6;
    localparam int PTR_MSB  = 6;
    localparam int INC_BIT  = 7;
    localparam int GPO_MSB  = 5;
    localparam int GP_PIN_ENABLE_BIT = 6;
    localparam int OVER_BIT = 7;

    // Codes at or below this are silent
    localparam logic [7:0] ATT_MUTE_MAX = 8'h80;
    localparam logic [7:0] ATT_FULL     = 8'hff;

endpackage : dacmc_pkg

`default_nettype wire

// ===== hw/dacmc_pin_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes each pin level holds for five ref_clk periods.
`default_nettype none

module dacmc_pin_sync #(
    parameter int         WIDTH     = 1,
    parameter logic [2:0] RESET_VAL = 3'h0
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             reset,
    // Pins in, filtered levels out
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] stage1, stage2, stage3;

    // Three flops in series
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            stage1 <= WIDTH'(RESET_VAL);
            stage2 <= WIDTH'(RESET_VAL);
            stage3 <= WIDTH'(RESET_VAL);
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Take a bit once the last two stages agree
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            level_out <= WIDTH'(RESET_VAL);
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (stage2[i] == stage3[i]) begin
                    level_out[i] <= stage3[i];
                end
            end
        end
    end

endmodule : dacmc_pin_sync

`default_nettype wire

// ===== hw/dacmc_atten_ramp.sv
// One channel attenuator: walks its code one half-decibel step per tick unless level and target are both silent.
// Assumes step_tick is a one-cycle pulse.
`default_nettype none

module dacmc_atten_ramp (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // Control
    input  wire logic       step_tick,
    input  wire logic [7:0] programmed_level,
    input  wire logic       soft_silence_enable,
    // Applied level
    output logic      [7:0] applied_level,
    output logic            infinite_atten
);

    logic [7:0] target;
    logic       target_silent, now_silent;

    // Mute aims at code zero; low codes are silent
    assign target        = soft_silence_enable ? 8'h00 : programmed_level; // RULE_14
    assign target_silent = target <= dacmc_pkg::ATT_MUTE_MAX;
    assign now_silent    = applied_level <= dacmc_pkg::ATT_MUTE_MAX;

    // Step toward the target one code per tick, or load it at once when both are silent
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            applied_level <= dacmc_pkg::ATT_FULL;
        end else if (step_tick) begin
            if (target_silent && now_silent) begin
                applied_level <= target;  // RULE_15
            end else if (applied_level > target) begin
                applied_level <= applied_level - 8'h01; // RULE_14
            end else if (applied_level < target) begin
                applied_level <= applied_level + 8'h01; // RULE_14
            end
        end
    end

    // Silent flag registered from the level, one cycle behind it
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            infinite_atten <= 1'b0;
        end else begin
            infinite_atten <= now_silent; // RULE_15
        end
    end

endmodule : dacmc_atten_ramp

`default_nettype wire

// ===== hw/dacmc_mode_regs.sv
// Mode control register bank with four-wire serial control port.
// Assumes the host keeps the port timing.
//
// Operation
// RULE_01: Word is read/write bit, seven-bit index, then data byte.
// RULE_02: Read/write bit zero stores the data byte at the index.
// RULE_03: Read/write bit one returns register contents, stores nothing.
// RULE_04: Host avoids indices 00h and 0Dh to 0Fh.
// RULE_05: Host writes test-only bits as zero.
// RULE_06: Eight attenuation bytes at 01h-06h, 10h, 11h, reset to no attenuation.
// RULE_07: Audio format in low three bits of 09h, reset to 24-bit right-justified.
// RULE_08: Rolloff bit 5, clock halving bit 4, clock disable bit 3 at 09h.
// RULE_09: De-emphasis enables in low three bits of 0Ah, reset disabled.
// RULE_10: Rate bits 4:3, phase invert bit 5, zero-flag polarity bit 6 at 0Ah.
// RULE_11: General outputs 5:0, output enable 6, oversampling 7 at 0Ch.
// RULE_12: Auto-increment bit 7 and readback pointer 6:0 at 0Bh, pointer resets 01h.
// RULE_13: Reads ignore the word index and use the readback pointer.
// RULE_14: Soft mute ramps one step to silence and back to programmed level.
// RULE_15: Level is half-decibel times code minus 255; codes up to 128 silent.
// RULE_16: Disable bit switches output to common-mode; resets enabled.
// RULE_17: Mute bits at 07h bits 5:0 and 12h bits 1:0, reset off.
// RULE_18: Disable bits at 08h bits 5:0 and 13h bits 1:0.
`default_nettype none

module dacmc_mode_regs #(
    parameter int STEP_CYCLES = dacmc_pkg::RAMP_STEP_CYCLES
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // Serial control port pins
    input  wire logic        ctl_latch_n,
    input  wire logic        ctl_clock,
    input  wire logic        ctl_data_in,
    output logic             ctl_data_out,
    output logic             ctl_data_out_oe,
    // Channel controls
    output logic [63:0]      channel_attenuation_level,
    output logic [7:0]       channel_infinite_atten,
    output logic [7:0]       soft_silence_enable,
    output logic [7:0]       channel_output_off,
    // Format and clock output
    output logic [2:0]       audio_format_select,
    output logic             rolloff_select,
    output logic             clock_out_halving,
    output logic             clock_out_disable,
    // De-emphasis and flags
    output logic [2:0]       deemph_enable,
    output logic [1:0]       deemph_rate_select,
    output logic             output_phase_invert,
    output logic             zero_flag_polarity,
    // General-purpose pins and oversampling
    output logic [5:0]       gp_pin_values,
    output logic             gp_pin_enable,
    output logic             oversampling_select
);

    typedef enum logic [2:0] {
        PORT_IDLE   = 3'b001,
        PORT_HEADER = 3'b010,
        PORT_DATA   = 3'b100
    } dacmc_port_t;

    localparam logic [4:0] RISE_FULL = 5'(dacmc_pkg::WORD_BITS);
    localparam logic [4:0] RISE_SAT  = 5'(dacmc_pkg::WORD_BITS + 1);
    localparam logic [4:0] RISE_HDR  = 5'(dacmc_pkg::HEADER_BITS - 1);

    dacmc_port_t port_state;
    logic        ml_s, mc_s, mdi_s;
    logic        ml_prev, mc_prev;
    logic        frame_start, frame_end, mc_rise, mc_fall;
    logic [4:0]  rise_cnt;
    logic [15:0] word_in;
    logic        read_req;
    logic [2:0]  out_pos;
    logic [6:0]  read_idx;
    logic [7:0]  out_shift;
    logic [7:0]  read_word;
    logic        write_go;
    logic [6:0]  write_idx;
    logic [7:0]  write_data;

    logic [7:0]  attenuation [dacmc_pkg::CHANNELS];
    logic [7:0]  format_reg, deemph_reg, readback_reg, gp_reg;
    logic [31:0] tick_cnt;
    logic        step_tick;

    // Pin synchronisers; latch idles high
    dacmc_pin_sync #(
        .WIDTH     (1),
        .RESET_VAL (3'h1)
    ) u_sync_latch (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .pin_in    (ctl_latch_n),
        .level_out (ml_s)
    );

    dacmc_pin_sync #(
        .WIDTH     (2),
        .RESET_VAL (3'h0)
    ) u_sync_data (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .pin_in    ({ctl_clock, ctl_data_in}),
        .level_out ({mc_s, mdi_s})
    );

    // Edge history of the filtered pins
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ml_prev <= 1'b1;
            mc_prev <= 1'b0;
        end else begin
            ml_prev <= ml_s;
            mc_prev <= mc_s;
        end
    end

    assign frame_start = ml_prev & ~ml_s;
    assign frame_end   = ~ml_prev & ml_s;
    assign mc_rise     = ~mc_prev & mc_s & ~ml_s;
    assign mc_fall     = mc_prev & ~mc_s & ~ml_s;

    // Header of eight bits, then data phase
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            port_state <= PORT_IDLE;
        end else if (frame_end) begin
            port_state <= PORT_IDLE;
        end else if (frame_start) begin
            port_state <= PORT_HEADER;
        end else if (port_state == PORT_HEADER && mc_rise && rise_cnt == RISE_HDR) begin
            port_state <= PORT_DATA;
        end
    end

    // Rising edges counted, saturating beyond a full word
    always_ff @(posedge ref_clk) begin
        if (reset || frame_start) begin
            rise_cnt <= 5'h00;
        end else if (mc_rise && rise_cnt != RISE_SAT) begin
            rise_cnt <= rise_cnt + 5'h01;
        end
    end

    // Input word shifted MSB first; top bit marks a read
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            word_in  <= 16'h0000;
            read_req <= 1'b0;
        end else if (frame_start) begin
            word_in  <= 16'h0000;
            read_req <= 1'b0;
        end else if (mc_rise && rise_cnt < RISE_FULL) begin
            word_in <= {word_in[14:0], mdi_s}; // RULE_01
            if (rise_cnt == 5'h00) begin
                read_req <= mdi_s; // RULE_03
            end
        end
    end

    // Write commits at latch rise after exactly sixteen bits
    assign write_idx  = word_in[dacmc_pkg::IDX_MSB:dacmc_pkg::IDX_LSB];
    assign write_data = word_in[7:0];
    assign write_go   = frame_end && rise_cnt == RISE_FULL
                        && !word_in[dacmc_pkg::RW_BIT]; // RULE_02

    // Auto-increment step, skipping the gap and wrapping
    function automatic logic [6:0] next_index(input logic [6:0] idx);
        if (idx == dacmc_pkg::IDX_OFF_B) begin
            next_index = dacmc_pkg::IDX_ATT1;
        end else if (idx == dacmc_pkg::IDX_GP) begin
            next_index = dacmc_pkg::IDX_ATT7;
        end else begin
            next_index = idx + dacmc_pkg::IDX_STEP;
        end
    endfunction : next_index

    // Readback multiplexer; unmapped indices read zero
    always_comb begin
        unique case (read_idx)
            dacmc_pkg::IDX_ATT1:     read_word = attenuation[0];
            dacmc_pkg::IDX_ATT2:     read_word = attenuation[1];
            dacmc_pkg::IDX_ATT3:     read_word = attenuation[2];
            dacmc_pkg::IDX_ATT4:     read_word = attenuation[3];
            dacmc_pkg::IDX_ATT5:     read_word = attenuation[4];
            dacmc_pkg::IDX_ATT6:     read_word = attenuation[5];
            dacmc_pkg::IDX_MUTE_A:   read_word = {2'h0, soft_silence_enable[5:0]};
            dacmc_pkg::IDX_OFF_A:    read_word = {2'h0, channel_output_off[5:0]};
            dacmc_pkg::IDX_FORMAT:   read_word = format_reg;
            dacmc_pkg::IDX_DEEMPH:   read_word = deemph_reg;
            dacmc_pkg::IDX_READBACK: read_word = readback_reg;
            dacmc_pkg::IDX_GP:       read_word = gp_reg;
            dacmc_pkg::IDX_ATT7:     read_word = attenuation[6];
            dacmc_pkg::IDX_ATT8:     read_word = attenuation[7];
            dacmc_pkg::IDX_MUTE_B:   read_word = {6'h00, soft_silence_enable[7:6]};
            dacmc_pkg::IDX_OFF_B:    read_word = {6'h00, channel_output_off[7:6]};
            default:                 read_word = 8'h00;
        endcase
    end

    // Read data driven on falling edges, one byte per eight clocks
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            out_pos      <= 3'h0;
            read_idx     <= dacmc_pkg::READBACK_RESET[6:0];
            out_shift    <= 8'h00;
            ctl_data_out <= 1'b0;
        end else if (frame_start) begin
            out_pos  <= 3'h0;
            read_idx <= readback_reg[dacmc_pkg::PTR_MSB:0]; // RULE_13
        end else if (port_state == PORT_DATA && read_req && mc_fall) begin
            out_pos <= out_pos + 3'h1;
            if (out_pos == 3'h0) begin
                ctl_data_out <= read_word[7];
                out_shift    <= {read_word[6:0], 1'b0};
                if (readback_reg[dacmc_pkg::INC_BIT]) begin
                    read_idx <= next_index(read_idx); // RULE_12
                end
            end else begin
                ctl_data_out <= out_shift[7];
                out_shift    <= {out_shift[6:0], 1'b0};
            end
        end
    end

    // Output enable from the first data bit to the latch rising
    always_ff @(posedge ref_clk) begin
        if (reset || frame_end || frame_start) begin
            ctl_data_out_oe <= 1'b0;
        end else if (port_state == PORT_DATA && read_req && mc_fall) begin
            ctl_data_out_oe <= 1'b1; // RULE_03
        end
    end

    // Attenuation registers per channel
    generate
        for (genvar ch = 0; ch < dacmc_pkg::CHANNELS; ch++) begin : g_att
            localparam logic [6:0] MY_IDX = (ch < dacmc_pkg::CH_LOW)
                ? 7'(int'(dacmc_pkg::IDX_ATT1) + ch)
                : 7'(int'(dacmc_pkg::IDX_ATT7) + ch - dacmc_pkg::CH_LOW);

            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    attenuation[ch] <= dacmc_pkg::ATT_RESET; // RULE_06
                end else if (write_go && write_idx == MY_IDX) begin
                    attenuation[ch] <= write_data; // RULE_06
                end
            end

            dacmc_atten_ramp u_ramp (
                .ref_clk             (ref_clk),
                .reset               (reset),
                .step_tick           (step_tick),
                .programmed_level    (attenuation[ch]),
                .soft_silence_enable (soft_silence_enable[ch]),
                .applied_level       (channel_attenuation_level[ch*8 +: 8]),
                .infinite_atten      (channel_infinite_atten[ch])
            );
        end
    endgenerate

    // Mute and disable bits
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            soft_silence_enable <= dacmc_pkg::MUTE_RESET; // RULE_17
            channel_output_off  <= dacmc_pkg::OFF_RESET;  // RULE_16
        end else if (write_go) begin
            unique case (write_idx)
                dacmc_pkg::IDX_MUTE_A: soft_silence_enable[5:0] <= write_data[5:0]; // RULE_17
                dacmc_pkg::IDX_MUTE_B: soft_silence_enable[7:6] <= write_data[1:0]; // RULE_17
                dacmc_pkg::IDX_OFF_A:  channel_output_off[5:0]  <= write_data[5:0]; // RULE_18
                dacmc_pkg::IDX_OFF_B:  channel_output_off[7:6]  <= write_data[1:0]; // RULE_18
                default: ;
            endcase
        end
    end

    // Format, de-emphasis, readback, general-purpose
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            format_reg   <= dacmc_pkg::FORMAT_RESET;   // RULE_07 RULE_08
            deemph_reg   <= dacmc_pkg::DEEMPH_RESET;   // RULE_09 RULE_10
            readback_reg <= dacmc_pkg::READBACK_RESET; // RULE_12
            gp_reg       <= dacmc_pkg::GP_RESET;       // RULE_11
        end else if (write_go) begin
            unique case (write_idx)
                dacmc_pkg::IDX_FORMAT: begin
                    format_reg <= write_data & dacmc_pkg::MASK_FORMAT; // RULE_07 RULE_08
                end
                dacmc_pkg::IDX_DEEMPH: begin
                    deemph_reg <= write_data & dacmc_pkg::MASK_DEEMPH; // RULE_09 RULE_10
                end
                dacmc_pkg::IDX_READBACK: readback_reg <= write_data; // RULE_12
                dacmc_pkg::IDX_GP:       gp_reg <= write_data; // RULE_11
                default: ;
            endcase
        end
    end

    // Field outputs
    assign audio_format_select = format_reg[dacmc_pkg::FMT_MSB:dacmc_pkg::FMT_LSB];
    assign rolloff_select      = format_reg[dacmc_pkg::FLT_BIT];
    assign clock_out_halving   = format_reg[dacmc_pkg::CLOCK_OUT_HALVING_BIT];
    assign clock_out_disable   = format_reg[dacmc_pkg::CLOCK_OUT_DISABLE_BIT];
    assign deemph_enable       = deemph_reg[dacmc_pkg::DMC_MSB:dacmc_pkg::DMC_LSB];
    assign deemph_rate_select  = deemph_reg[dacmc_pkg::DMF_MSB:dacmc_pkg::DMF_LSB];
    assign output_phase_invert = deemph_reg[dacmc_pkg::OUTPUT_PHASE_INVERT_BIT];
    assign zero_flag_polarity  = deemph_reg[dacmc_pkg::ZERO_FLAG_POLARITY_BIT];
    assign gp_pin_values       = gp_reg[dacmc_pkg::GPO_MSB:0];
    assign gp_pin_enable       = gp_reg[dacmc_pkg::GP_PIN_ENABLE_BIT];
    assign oversampling_select = gp_reg[dacmc_pkg::OVER_BIT];

    // Shared attenuator step timer
    always_ff @(posedge ref_clk) begin
        if (reset || step_tick) begin
            tick_cnt <= 32'h0000_0000;
        end else begin
            tick_cnt <= tick_cnt + 32'h0000_0001;
        end
    end

    assign step_tick = tick_cnt == 32'(STEP_CYCLES - 1);

endmodule : dacmc_mode_regs

`default_nettype wire

// ===== testbench/dacmc_mode_props.sv
// Checker for the mode register bank.
// Assumes it is bound to every dacmc_mode_regs instance.
`default_nettype none
module dacmc_mode_props #(
    parameter int STEP_CYCLES = 4
) (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        reset,
    // Port pins
    input wire logic        ctl_latch_n,
    input wire logic        ctl_data_out_oe,
    // Channel controls
    input wire logic [63:0] channel_attenuation_level,
    input wire logic [7:0]  channel_infinite_atten,
    input wire logic [7:0]  soft_silence_enable,
    input wire logic [7:0]  channel_output_off,
    // Mode fields
    input wire logic [2:0]  audio_format_select,
    input wire logic        rolloff_select,
    input wire logic        clock_out_halving,
    input wire logic        clock_out_disable,
    input wire logic [2:0]  deemph_enable,
    input wire logic [1:0]  deemph_rate_select,
    input wire logic        output_phase_invert,
    input wire logic        zero_flag_polarity,
    input wire logic [5:0]  gp_pin_values,
    input wire logic        gp_pin_enable,
    input wire logic        oversampling_select
);
    timeunit 1ns;
    timeprecision 1ps;
    // Channel one level and all mode fields in register order
    wire logic [7:0]  lv = channel_attenuation_level[7:0];
    wire logic [20:0] modes = {rolloff_select, clock_out_halving, clock_out_disable,
        audio_format_select, zero_flag_polarity, output_phase_invert, deemph_rate_select,
        deemph_enable, oversampling_select, gp_pin_enable, gp_pin_values};
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    rst_atten_a: assert property ($fell(reset) |-> &channel_attenuation_level)
        else $error("attenuation not ff after reset");
    rst_chan_a: assert property (
        $fell(reset) |-> {soft_silence_enable, channel_output_off} == 16'h0)
        else $error("channel bits not clear after reset");
    rst_modes_a: assert property (
        $fell(reset) |-> modes == 21'h0)
        else $error("mode fields not clear after reset");
    idle_hiz_a: assert property (ctl_latch_n [*8] |-> !ctl_data_out_oe)
        else $error("data out driven outside a frame");
    oe_frame_a: assert property ($rose(ctl_data_out_oe) |-> !ctl_latch_n)
        else $error("data out enabled without latch low");
    quiet_frame_a: assert property (
        !ctl_latch_n [*8] |-> $stable({modes, soft_silence_enable, channel_output_off}))
        else $error("register changed inside a frame");
    flag_lag_a: assert property (
        1'b1 |=> channel_infinite_atten[0] == ($past(lv) <= 8'h80))
        else $error("infinite flag wrong for level");
    ramp_step_a: assert property ($changed(lv) |->
        lv == 8'($past(lv) + 8'h01) || lv == 8'($past(lv) - 8'h01)
        || (lv <= 8'h80 && $past(lv) <= 8'h80))
        else $error("level moved by more than one step");
    // Main scenarios reached
    cover property ($rose(ctl_data_out_oe));
    cover property ($rose(channel_infinite_atten[0]));
    cover property ($fell(soft_silence_enable[0]));
endmodule : dacmc_mode_props
bind dacmc_mode_regs dacmc_mode_props #(.STEP_CYCLES(STEP_CYCLES)) props_u (.*);
`default_nettype wire

// ===== testbench/dacmc_host_model.sv
// Behavioural host on the four-wire control port.
// Assumes frames are started only after reset has been released.
`default_nettype none
module dacmc_host_model (
    // Clock
    input  wire logic ref_clk,
    // Control port
    output var  logic ctl_latch_n,
    output var  logic ctl_clock,
    output var  logic ctl_data_in,
    input  wire logic ctl_data_out,
    input  wire logic ctl_data_out_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle levels
    initial begin
        ctl_latch_n = 1'b1;
        ctl_clock   = 1'b0;
        ctl_data_in = 1'b0;
    end
    // Pin levels change at falling edges and hold 80 ns
    task automatic hold(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : hold
    // One frame, MSB first; extra bytes clock out more read data
    task automatic frame(input logic [15:0] word, input int extra, output logic [15:0] rd);
        rd = 16'h0000;
        ctl_latch_n = 1'b0;
        for (int i = 0; i < 16 + 8 * extra; i++) begin
            ctl_data_in = (i < 16) ? word[15 - i] : ~ctl_data_in;
            hold(8);
            ctl_clock = 1'b1;
            if (i >= 8) rd = {rd[14:0], ctl_data_out & ctl_data_out_oe};
            hold(8);
            ctl_clock = 1'b0;
        end
        hold(8);
        ctl_latch_n = 1'b1;
        hold(32);
    endtask : frame
endmodule : dacmc_host_model
`default_nettype wire

// ===== testbench/test_dac_mode_control_register_bank.sv
// Self-checking bench for the mode control register bank.
// Assumes the host model drives the pins; ramp tick set to 4.
`default_nettype none
module test_dac_mode_control_register_bank;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    wire logic ctl_latch_n, ctl_clock, ctl_data_in, ctl_data_out, ctl_data_out_oe;
    wire logic [63:0] channel_attenuation_level;
    wire logic [7:0] channel_infinite_atten, soft_silence_enable, channel_output_off;
    wire logic [2:0] audio_format_select, deemph_enable;
    wire logic [1:0] deemph_rate_select;
    wire logic [5:0] gp_pin_values;
    wire logic rolloff_select, clock_out_halving, clock_out_disable, output_phase_invert;
    wire logic zero_flag_polarity, gp_pin_enable, oversampling_select;
    int miscompares = 0;
    int checks = 0;
    logic [15:0] rd;
    // Index and data of each write, reserved test bits zero
    localparam logic [15:0] TBL [15] = '{16'h01a5, 16'h02b6, 16'h03c7, 16'h04d8, 16'h05e9,
        16'h06fa, 16'h0715, 16'h082a, 16'h092d, 16'h0a5b, 16'h0ca9, 16'h1090, 16'h1181,
        16'h1202, 16'h1301};
    // Grouped outputs in register bit order
    wire logic [15:0] chans = {soft_silence_enable, channel_output_off};
    wire logic [20:0] modes = {rolloff_select, clock_out_halving, clock_out_disable,
        audio_format_select, zero_flag_polarity, output_phase_invert, deemph_rate_select,
        deemph_enable, oversampling_select, gp_pin_enable, gp_pin_values};
    dacmc_mode_regs #(.STEP_CYCLES(4)) dut_u (.*);
    dacmc_host_model host_u (.*);
    always #5 ref_clk = ~ref_clk;
    task automatic chk(input logic [63:0] got, exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [6:0] idx, input logic [7:0] val);
        host_u.frame({1'b0, idx, val}, 0, rd);
    endtask : wr
    // Point readback at idx; read with another word index
    task automatic rdreg(input logic [6:0] idx, output logic [7:0] val);
        wr(7'h0b, {1'b0, idx});
        host_u.frame(16'h9300, 0, rd);
        val = rd[7:0];
    endtask : rdreg
    task automatic t_reset;
        chk(channel_attenuation_level, {8{8'hff}});
        chk(chans, 16'h0);
        chk(modes, 21'h0);
        host_u.frame(16'h8c00, 0, rd);
        chk(rd[7:0], 8'hff);
        $display("reset test done");
    endtask : t_reset
    task automatic t_table;
        logic [7:0] v;
        foreach (TBL[i]) wr(TBL[i][14:8], TBL[i][7:0]);
        foreach (TBL[i]) begin
            rdreg(TBL[i][14:8], v);
            chk(v, TBL[i][7:0]);
        end
        chk(chans, 16'h956a);
        chk(modes, {6'h2d, 7'h5b, 8'ha9});
        $display("register test done");
    endtask : t_table
    task automatic t_auto;
        wr(7'h0b, 8'h8c);
        host_u.frame(16'h8c00, 1, rd);
        chk(rd, 16'ha990);
        wr(7'h0b, 8'h93);
        host_u.frame(16'h8900, 1, rd);
        chk(rd, 16'h01a5);
        chk(modes, {6'h2d, 7'h5b, 8'ha9});
        $display("auto-increment test done");
    endtask : t_auto
    task automatic t_ramp;
        int n;
        wr(7'h07, 8'h00);
        for (n = 0; n < 3000 && channel_attenuation_level[7:0] !== 8'ha5; n++)
            @(negedge ref_clk);
        chk(channel_attenuation_level[7:0], 8'ha5);
        chk({channel_attenuation_level[63:48], channel_infinite_atten}, 24'h009080);
        wr(7'h07, 8'h01);
        for (n = 0; n < 3000 && channel_attenuation_level[7:0] !== 8'h00; n++)
            @(negedge ref_clk);
        chk({channel_attenuation_level[7:0], channel_infinite_atten[0]}, 9'h001);
        $display("ramp test done");
    endtask : t_ramp
    task automatic test_done;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    // Main sequence
    initial begin
        repeat (5) @(negedge ref_clk);
        reset = 1'b0;
        repeat (5) @(negedge ref_clk);
        t_reset();
        t_table();
        t_auto();
        t_ramp();
        test_done();
    end
    // Watchdog
    initial begin
        #600us;
        miscompares++;
        test_done();
    end
endmodule : test_dac_mode_control_register_bank
`default_nettype wire
